// ### design/phy_pins.sv
// status leds, straps, general purpose outputs and interrupt pin of the phy
// Functional notes
// - speed led active at 100 Mbit/s, inactive at 10 Mbit/s.
// - link led active while a 100 or 10 link is up.
// - activity led active while the active medium sublayer reports carrier.
// - duplex led active in full duplex, inactive in half duplex.
// - five address straps give the default management address, bits 0 to 4.
// - interrupt is open drain, pulled low when asserted, released otherwise.
// - external reset is active low; device held in reset while low.
// - device runs from a 25 MHz reference clock or crystal.
// - three general outputs driven from bits in registers 27 and 31.
// - general output 1 shares its pin with address strap bit 4.
// - management clock is an input; one two-way management data line.
// - carrier sense asserted when carrier detected; activity follows it.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module phy_pins #(
	parameter int DIV = phy_pins_pkg::REF_DIV
) (
	input wire logic clk_sys,
	input wire logic ext_reset_n,
	input wire logic [phy_pins_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [phy_pins_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [phy_pins_pkg::DATA_W-1:0] reg_rdata,
	input wire phy_pins_pkg::phy_state_s phy_state,
	input wire logic status_led_one_i,
	output logic status_led_one_o,
	output logic status_led_one_oe,
	input wire logic status_led_two_i,
	output logic status_led_two_o,
	output logic status_led_two_oe,
	input wire logic status_led_three_i,
	output logic status_led_three_o,
	output logic status_led_three_oe,
	input wire logic status_led_four_i,
	output logic status_led_four_o,
	output logic status_led_four_oe,
	input wire logic opmode_strap_bit0,
	input wire logic opmode_strap_bit1,
	input wire logic opmode_strap_bit2,
	input wire logic gp_out0_i,
	output logic gp_out0_o,
	output logic gp_out0_oe,
	input wire logic gp_out1_i,
	output logic gp_out1_o,
	output logic gp_out1_oe,
	output logic gp_out2,
	output logic irq_out_n_o,
	output logic irq_out_n_oe,
	input wire logic refclk_select,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe,
	output logic carrier_sense,
	output phy_pins_pkg::strap_s active_cfg
);
	import phy_pins_pkg::*;

	initial begin
		if (DIV < 1 || DIV * REF_CLK_HZ != SYS_CLK_HZ) begin
			$error("phy_pins: DIV must divide the system clock to the reference rate");
		end
	end

	// ==========================================================
	// reference rate enable
	logic ref_tick;

	ref_tick_gen #(
		.DIV(DIV)
	) u_tick (
		.clk_sys(clk_sys),
		.ext_reset_n(ext_reset_n),
		.tick(ref_tick)
	);

	// ==========================================================
	// start-up: straps then drive
	start_e state_q, state_d;
	strap_s strap_q, strap_d;
	strap_s cfg_q, cfg_d;
	logic drive_q, drive_d;

	// address decode shared by writes and reads
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] idx);
		hit = (a == idx);
	endfunction

	// capture straps in the first cycle after reset release, pins still released
	always_comb begin
		state_d = state_q;
		strap_d = strap_q;
		cfg_d = cfg_q;
		drive_d = drive_q;
		case (state_q)
			ST_CAPTURE: begin
				strap_d.addr = {gp_out1_i, status_led_four_i, status_led_three_i,
					status_led_two_i, status_led_one_i};
				strap_d.mode = {opmode_strap_bit2, opmode_strap_bit1, opmode_strap_bit0};
				strap_d.mii_sel = gp_out0_i;
				cfg_d = strap_d;
				drive_d = 1'b1;
				state_d = ST_RUN;
			end
			default: begin
				if (reg_wr && hit(reg_addr, CFG_IDX)) begin
					cfg_d.addr = reg_wdata[CFG_ADDR_LSB +: 5];
					cfg_d.mode = reg_wdata[CFG_MODE_LSB +: 3];
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			state_q <= ST_CAPTURE;
			strap_q <= '0;
			cfg_q <= '0;
			drive_q <= 1'b0;
		end else begin
			state_q <= state_d;
			strap_q <= strap_d;
			cfg_q <= cfg_d;
			drive_q <= drive_d;
		end
	end

	// ==========================================================
	// status leds, updated at the reference rate
	logic [3:0] led_q, led_d;
	logic crs_q, crs_d;

	always_comb begin
		led_d = led_q;
		crs_d = crs_q;
		if (ref_tick) begin
			crs_d = phy_state.carrier;
			led_d[0] = phy_state.speed_100 ? LED_ACTIVE : ~LED_ACTIVE;
			led_d[1] = phy_state.link_up ? LED_ACTIVE : ~LED_ACTIVE;
			led_d[2] = phy_state.carrier ? LED_ACTIVE : ~LED_ACTIVE;
			led_d[3] = phy_state.full_duplex ? LED_ACTIVE : ~LED_ACTIVE;
		end
	end

	always_ff @(posedge clk_sys or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			led_q <= {4{~LED_ACTIVE}};
			crs_q <= 1'b0;
		end else begin
			led_q <= led_d;
			crs_q <= crs_d;
		end
	end

	// ==========================================================
	// general purpose outputs
	logic [2:0] gpo_q, gpo_d;

	always_comb begin
		gpo_d = gpo_q;
		if (reg_wr && hit(reg_addr, GPO_A_IDX)) begin
			gpo_d[0] = reg_wdata[GPO_A_OUT0_BIT];
			gpo_d[1] = reg_wdata[GPO_A_OUT1_BIT];
		end else if (reg_wr && hit(reg_addr, GPO_B_IDX)) begin
			gpo_d[2] = reg_wdata[GPO_B_OUT2_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			gpo_q <= GPO_RST;
		end else begin
			gpo_q <= gpo_d;
		end
	end

	// ==========================================================
	// events, sticky status and mask
	phy_state_s prev_q;
	logic [EV_W-1:0] ev_stat_q, ev_stat_d, ev_mask_q, ev_mask_d;
	logic [EV_W-1:0] ev_set;
	logic irq_q, irq_d;

	// set beats a write-one clear in the same cycle
	always_comb begin
		ev_set = '0;
		ev_set[EV_LINK] = prev_q.link_up ^ phy_state.link_up;
		ev_set[EV_SPEED] = prev_q.speed_100 ^ phy_state.speed_100;
		ev_set[EV_DUPLEX] = prev_q.full_duplex ^ phy_state.full_duplex;
		ev_set[EV_REFSEL] = refclk_select;
		ev_stat_d = ev_stat_q;
		ev_mask_d = ev_mask_q;
		if (reg_wr && hit(reg_addr, IRQ_STAT_IDX)) begin
			ev_stat_d = ev_stat_q & ~reg_wdata[EV_W-1:0];
		end else if (reg_wr && hit(reg_addr, IRQ_MASK_IDX)) begin
			ev_mask_d = reg_wdata[EV_W-1:0];
		end
		ev_stat_d = ev_stat_d | ev_set;
		irq_d = |(ev_stat_q & ev_mask_q);
	end

	always_ff @(posedge clk_sys or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			prev_q <= '0;
			ev_stat_q <= '0;
			ev_mask_q <= IRQ_MASK_RST;
			irq_q <= 1'b0;
		end else begin
			prev_q <= phy_state;
			ev_stat_q <= ev_stat_d;
			ev_mask_q <= ev_mask_d;
			irq_q <= irq_d;
		end
	end

	// ==========================================================
	// register read port, data one cycle after the strobe
	logic [DATA_W-1:0] rdata_d, rdata_q;

	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			if (hit(reg_addr, PIN_STAT_IDX)) begin
				rdata_d[PST_LINK_BIT] = phy_state.link_up;
				rdata_d[PST_SPEED_BIT] = phy_state.speed_100;
				rdata_d[PST_DUPLEX_BIT] = phy_state.full_duplex;
				rdata_d[PST_CRS_BIT] = crs_q;
				rdata_d[PST_REFSEL_BIT] = refclk_select;
				rdata_d[PST_MDC_BIT] = mdc;
				rdata_d[PST_MDIO_BIT] = mdio_i;
			end else if (hit(reg_addr, CFG_IDX)) begin
				rdata_d[CFG_ADDR_LSB +: 5] = cfg_q.addr;
				rdata_d[CFG_MODE_LSB +: 3] = cfg_q.mode;
				rdata_d[CFG_MIISEL_BIT] = strap_q.mii_sel;
			end else if (hit(reg_addr, GPO_A_IDX)) begin
				rdata_d[GPO_A_OUT0_BIT] = gpo_q[0];
				rdata_d[GPO_A_OUT1_BIT] = gpo_q[1];
			end else if (hit(reg_addr, GPO_B_IDX)) begin
				rdata_d[GPO_B_OUT2_BIT] = gpo_q[2];
			end else if (hit(reg_addr, IRQ_STAT_IDX)) begin
				rdata_d[EV_W-1:0] = ev_stat_q;
			end else if (hit(reg_addr, IRQ_MASK_IDX)) begin
				rdata_d[EV_W-1:0] = ev_mask_q;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// pin drivers, all from flops or constants
	// pins released until straps taken
	assign status_led_one_o = led_q[0];
	assign status_led_two_o = led_q[1];
	assign status_led_three_o = led_q[2];
	assign status_led_four_o = led_q[3];
	assign status_led_one_oe = drive_q;
	assign status_led_two_oe = drive_q;
	assign status_led_three_oe = drive_q;
	assign status_led_four_oe = drive_q;
	assign gp_out1_o = gpo_q[1];
	assign gp_out1_oe = drive_q;
	assign gp_out0_o = gpo_q[0];
	assign gp_out0_oe = drive_q;
	assign gp_out2 = gpo_q[2];
	assign irq_out_n_o = 1'b0;
	assign irq_out_n_oe = irq_q;
	// frame engine lives elsewhere; data line left released here
	assign mdio_o = 1'b0;
	assign mdio_oe = 1'b0;
	assign carrier_sense = crs_q;
	assign active_cfg = cfg_q;
	assign reg_rdata = rdata_q;
endmodule

// ### design/phy_pins_pkg.sv
// shared constants, types and register map for the phy pin block
package phy_pins_pkg;

	// ==========================================================
	// clocking
	localparam int SYS_CLK_HZ = 50_000_000;
	localparam int REF_CLK_HZ = 25_000_000;
	localparam int REF_DIV = SYS_CLK_HZ / REF_CLK_HZ;

	// ==========================================================
	// register port
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] PIN_STAT_IDX = 5'h11;
	localparam logic [4:0] CFG_IDX = 5'h12;
	localparam logic [4:0] GPO_A_IDX = 5'h1B;
	localparam logic [4:0] IRQ_STAT_IDX = 5'h1C;
	localparam logic [4:0] IRQ_MASK_IDX = 5'h1D;
	localparam logic [4:0] GPO_B_IDX = 5'h1F;

	// ==========================================================
	// field positions
	localparam int CFG_ADDR_LSB = 0;
	localparam int CFG_MODE_LSB = 5;
	localparam int CFG_MIISEL_BIT = 8;
	localparam int GPO_A_OUT0_BIT = 0;
	localparam int GPO_A_OUT1_BIT = 1;
	localparam int GPO_B_OUT2_BIT = 0;
	localparam int PST_LINK_BIT = 0;
	localparam int PST_SPEED_BIT = 1;
	localparam int PST_DUPLEX_BIT = 2;
	localparam int PST_CRS_BIT = 3;
	localparam int PST_REFSEL_BIT = 4;
	localparam int PST_MDC_BIT = 5;
	localparam int PST_MDIO_BIT = 6;

	// ==========================================================
	// events and reset values
	localparam int EV_W = 4;
	localparam int EV_LINK = 0;
	localparam int EV_SPEED = 1;
	localparam int EV_DUPLEX = 2;
	localparam int EV_REFSEL = 3;
	localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;
	localparam logic [2:0] GPO_RST = 3'h0;
	localparam logic LED_ACTIVE = 1'b1;

	// ==========================================================
	// types
	typedef enum logic {ST_CAPTURE, ST_RUN} start_e;

	typedef struct packed {
		logic speed_100;
		logic link_up;
		logic carrier;
		logic full_duplex;
	} phy_state_s;

	typedef struct packed {
		logic [4:0] addr;
		logic [2:0] mode;
		logic mii_sel;
	} strap_s;

endpackage

// ### design/ref_tick_gen.sv
// divider giving a one-cycle enable at the reference rate
`timescale 1ns/100ps
module ref_tick_gen #(
	parameter int DIV = 2
) (
	input wire logic clk_sys,
	input wire logic ext_reset_n,
	output logic tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [CW-1:0] cnt_q, cnt_d;
	logic tick_d;

	initial begin
		if (DIV < 1) begin
			$error("ref_tick_gen: DIV must be at least one");
		end
	end

	// wrap counter, pulse on wrap
	always_comb begin
		tick_d = (cnt_q == CW'(DIV - 1));
		cnt_d = tick_d ? '0 : cnt_q + 1'b1;
	end

	always_ff @(posedge clk_sys or negedge ext_reset_n) begin
		if (!ext_reset_n) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick <= tick_d;
		end
	end
endmodule

// ### verif/phy_pins_sva.sv
// port assertions for the phy pin block
`timescale 1ns/100ps
module phy_pins_sva
	import phy_pins_pkg::*;
(
	input wire logic clk_sys,
	input wire logic ext_reset_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire phy_state_s phy_state,
	input wire logic status_led_one_o,
	input wire logic status_led_two_o,
	input wire logic status_led_three_o,
	input wire logic status_led_four_o,
	input wire logic status_led_one_oe,
	input wire logic gp_out0_o,
	input wire logic gp_out1_o,
	input wire logic irq_out_n_o,
	input wire logic irq_out_n_oe,
	input wire logic mdio_oe,
	input wire strap_s active_cfg
);
	// ==========================================================
	// leds follow a settled phy state
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!ext_reset_n);
	a_speed_led: assert property ($stable(phy_state)[*3] ##0 status_led_one_oe |->
		status_led_one_o == phy_state.speed_100) else $error("speed led wrong");
	a_link_led: assert property ($stable(phy_state)[*3] ##0 status_led_one_oe |->
		status_led_two_o == phy_state.link_up) else $error("link led wrong");
	a_activity_led: assert property ($stable(phy_state)[*3] ##0 status_led_one_oe |->
		status_led_three_o == phy_state.carrier) else $error("activity led wrong");
	a_duplex_led: assert property ($stable(phy_state)[*3] ##0 status_led_one_oe |->
		status_led_four_o == phy_state.full_duplex) else $error("duplex led wrong");
	// ==========================================================
	// pins, outputs and held configuration
	a_irq_drive_low: assert property (irq_out_n_oe |-> !irq_out_n_o) else $error("irq pin driven high");
	a_gpo_write: assert property (reg_wr && reg_addr == GPO_A_IDX |=>
		{gp_out1_o, gp_out0_o} == $past(reg_wdata[1:0])) else $error("gpo not written");
	a_irq_mask_off: assert property (reg_wr && reg_addr == IRQ_MASK_IDX && reg_wdata[EV_W-1:0] == '0 |=> ##1
		!irq_out_n_oe) else $error("irq held with all masked");
	a_mdio_released: assert property (!mdio_oe) else $error("mdio driven");
	a_cfg_hold: assert property (status_led_one_oe && !(reg_wr && reg_addr == CFG_IDX) |=>
		$stable(active_cfg)) else $error("cfg changed without write");
endmodule
bind phy_pins phy_pins_sva u_sva (.clk_sys, .ext_reset_n, .reg_addr, .reg_wdata, .reg_wr, .phy_state,
	.status_led_one_o, .status_led_two_o, .status_led_three_o, .status_led_four_o, .status_led_one_oe,
	.gp_out0_o, .gp_out1_o, .irq_out_n_o, .irq_out_n_oe, .mdio_oe, .active_cfg);

// ### verif/phy_board_model.sv
// board model: strap resistors, pulled pins, idle management lines
`timescale 1ns/100ps
module phy_board_model (
	input wire logic [4:0] strap_addr,
	input wire logic [2:0] strap_mode,
	input wire logic [3:0] led_o,
	input wire logic [3:0] led_oe,
	input wire logic [1:0] gpo_o,
	input wire logic [1:0] gpo_oe,
	input wire logic irq_o,
	input wire logic irq_oe,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	output logic [3:0] led_pin,
	output logic [1:0] gpo_pin,
	output logic irq_pin_n,
	output logic [2:0] mode_pin,
	output logic refclk_select,
	output logic mdc,
	output logic mdio_pin
);
	// ==========================================================
	// pin resolution
	// address straps show only while released; mode straps always show
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			led_pin[i] = led_oe[i] ? led_o[i] : strap_addr[i];
		end
		gpo_pin[1] = gpo_oe[1] ? gpo_o[1] : strap_addr[4];
		gpo_pin[0] = gpo_oe[0] & gpo_o[0];
	end
	assign irq_pin_n = irq_oe ? irq_o : 1'b1;
	assign refclk_select = 1'b0;
	assign mdc = 1'b0;
	assign mdio_pin = mdio_oe ? mdio_o : 1'b1;
	assign mode_pin = strap_mode;
endmodule

// ### verif/tb.sv
// self-checking bench for the phy pin block
`timescale 1ns/100ps
module tb;
	import phy_pins_pkg::*;
	logic clk_sys = 1'b0;
	logic ext_reset_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	phy_state_s phy_state = 4'h0;
	logic [4:0] s_addr = 5'h00;
	logic [2:0] s_mode = 3'h0;
	logic status_led_one_i, status_led_two_i, status_led_three_i, status_led_four_i;
	logic status_led_one_o, status_led_two_o, status_led_three_o, status_led_four_o;
	logic status_led_one_oe, status_led_two_oe, status_led_three_oe, status_led_four_oe;
	logic opmode_strap_bit0, opmode_strap_bit1, opmode_strap_bit2, gp_out2, carrier_sense;
	logic gp_out0_i, gp_out0_o, gp_out0_oe, gp_out1_i, gp_out1_o, gp_out1_oe;
	logic irq_out_n_o, irq_out_n_oe, irq_pin_n, refclk_select, mdc, mdio_i, mdio_o, mdio_oe;
	strap_s active_cfg;
	logic [15:0] exp_q[$];
	logic [15:0] v;
	logic rd_seen = 1'b0;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	phy_pins u_dut (.clk_sys, .ext_reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phy_state,
		.status_led_one_i, .status_led_one_o, .status_led_one_oe, .status_led_two_i, .status_led_two_o,
		.status_led_two_oe, .status_led_three_i, .status_led_three_o, .status_led_three_oe,
		.status_led_four_i, .status_led_four_o, .status_led_four_oe, .opmode_strap_bit0,
		.opmode_strap_bit1, .opmode_strap_bit2, .gp_out0_i, .gp_out0_o, .gp_out0_oe, .gp_out1_i,
		.gp_out1_o, .gp_out1_oe, .gp_out2, .irq_out_n_o, .irq_out_n_oe, .refclk_select, .mdc, .mdio_i,
		.mdio_o, .mdio_oe, .carrier_sense, .active_cfg);
	phy_board_model u_board (.strap_addr(s_addr), .strap_mode(s_mode),
		.led_o({status_led_four_o, status_led_three_o, status_led_two_o, status_led_one_o}),
		.led_oe({status_led_four_oe, status_led_three_oe, status_led_two_oe, status_led_one_oe}),
		.led_pin({status_led_four_i, status_led_three_i, status_led_two_i, status_led_one_i}),
		.gpo_o({gp_out1_o, gp_out0_o}), .gpo_oe({gp_out1_oe, gp_out0_oe}), .gpo_pin({gp_out1_i, gp_out0_i}),
		.irq_o(irq_out_n_o), .irq_oe(irq_out_n_oe), .irq_pin_n, .mdio_o, .mdio_oe, .refclk_select, .mdc,
		.mode_pin({opmode_strap_bit2, opmode_strap_bit1, opmode_strap_bit0}), .mdio_pin(mdio_i));
	// ==========================================================
	// clock, hang guard and answer monitor
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			end_sim();
		end
	end
	always @(negedge clk_sys) begin
		if (rd_seen) begin
			chk("read data", exp_q.pop_front(), reg_rdata);
		end
		rd_seen = reg_rd;
	end
	// ==========================================================
	// tasks
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(11578));
		for (int r = 0; r < 2; r++) begin
			// let the last read answer stand before reset clears it
			@(posedge clk_sys);
			s_addr <= 5'($urandom);
			s_mode <= 3'($urandom);
			ext_reset_n <= 1'b0;
			repeat (12) @(posedge clk_sys);
			ext_reset_n <= 1'b1;
			repeat (3) @(posedge clk_sys);
			chk("active cfg", {7'h0, s_addr, s_mode, 1'b0}, {7'h0, active_cfg});
			rd(CFG_IDX, {8'h0, s_mode, s_addr});
		end
		v = 16'($urandom);
		wr(CFG_IDX, v);
		rd(CFG_IDX, {8'h0, v[7:0]});
		$display("test straps done");
		for (int i = 0; i < 16; i++) begin
			phy_state <= 4'(i);
			repeat (4) @(posedge clk_sys);
			chk("leds", {12'h0, i[0], i[1], i[2], i[3]},
				{12'h0, status_led_four_i, status_led_three_i, status_led_two_i, status_led_one_i});
			chk("carrier", {15'h0, i[1]}, {15'h0, carrier_sense});
			rd(PIN_STAT_IDX, {9'h0, 3'b100, i[1], i[0], i[3], i[2]});
		end
		$display("test leds done");
		v = 16'($urandom);
		wr(GPO_A_IDX, v);
		wr(GPO_B_IDX, v >> 2);
		@(negedge clk_sys);
		chk("gpo", {13'h0, v[2:0]}, {13'h0, gp_out2, gp_out1_i, gp_out0_i});
		rd(GPO_A_IDX, {14'h0, v[1:0]});
		rd(GPO_B_IDX, {15'h0, v[2]});
		rd(5'h05, 16'h0000);
		$display("test gpo done");
		wr(IRQ_STAT_IDX, 16'h000F);
		wr(IRQ_MASK_IDX, 16'h0001);
		rd(IRQ_MASK_IDX, 16'h0001);
		for (int k = 0; k < 2; k++) begin
			phy_state[3-k] <= ~phy_state[3-k];
			repeat (3) @(posedge clk_sys);
			chk("irq pin", {15'h0, 1'(k == 0)}, {15'h0, irq_pin_n});
			rd(IRQ_STAT_IDX, 16'(2 + k));
		end
		wr(IRQ_STAT_IDX, 16'h0001);
		repeat (2) @(posedge clk_sys);
		chk("irq release", 16'h0001, {15'h0, irq_pin_n});
		// speed change is still pending: unmask it, then mask all
		wr(IRQ_MASK_IDX, 16'h0002);
		repeat (2) @(posedge clk_sys);
		chk("irq masked in", 16'h0000, {15'h0, irq_pin_n});
		wr(IRQ_MASK_IDX, 16'h0000);
		repeat (3) @(posedge clk_sys);
		chk("irq masked out", 16'h0001, {15'h0, irq_pin_n});
		$display("test irq done");
		end_sim();
	end
endmodule
